// ===== verilog/aiom_defs.vh
/*
 holds the constants of the process-data map block: slot layout, field positions,
 function codes, exception codes and reset values.
 assumes nothing; included by bare name.
*/
`ifndef AIOM_DEFS_VH
`define AIOM_DEFS_VH
`define AIOM_FC_READ_HOLD 8'h03
`define AIOM_FC_READ_INPUT 8'h04
`define AIOM_FC_WRITE_MULTI 8'h10
`define AIOM_MAX_COUNT 7'h7B
`define AIOM_ADDR_LIMIT 17'h003E8
`define AIOM_SLOT_WORDS 4'hA
`define AIOM_IDX_TYPE 4'h0
`define AIOM_IDX_RSVD 4'h1
`define AIOM_IDX_CH1 4'h2
`define AIOM_IDX_CH4 4'h5
`define AIOM_FRESH_BIT 8
`define AIOM_TYPE_LSB 0
`define AIOM_TYPE_W 8
`define AIOM_EXC_NONE 8'h00
`define AIOM_EXC_FUNC 8'h01
`define AIOM_EXC_ADDR 8'h02
`define AIOM_EXC_VALUE 8'h03
`define AIOM_CH_RESET 16'h0000
`endif

// ===== verilog/aiom_slot_decode.v
/*
 holds the slot decoder: splits a zero-based register address into slot and word.
 assumes addresses below one thousand; map digit range is checked by the caller.
*/
`timescale 1ns/1ps
`include "aiom_defs.vh"
module aiom_slot_decode (
	addr,
	slotNum,
	wordIdx
);
	input wire [15:0] addr;
	output wire [6:0] slotNum;
	output wire [3:0] wordIdx;
	// register number = address + 1; slot occupies numbers slot*10 .. slot*10+9
	wire [15:0] regNum;
	wire [15:0] quot;
	wire [15:0] rem;
	assign regNum = addr + 16'h0001;
	assign quot = regNum / 16'h000A;
	assign rem = regNum - quot * 16'h000A;
	assign slotNum = quot[6:0];
	assign wordIdx = rem[3:0];
endmodule

// ===== verilog/aiom_map.v
/*
 holds the process-data map for three analog extension slots: analog in, temperature
 in and analog out, reached by a decoded request port (function code, start address,
 count) stepping one read word per cycle, and one write word per wrValid pulse.
 assumes the framing layer hands over requests and write words synchronous to clk,
 and that the link side delivers input samples with a valid pulse.
*/
`timescale 1ns/1ps
`include "aiom_defs.vh"
module aiom_map #(
	parameter [6:0] AIN_SLOT = 7'h01,
	parameter [6:0] TEMP_SLOT = 7'h02,
	parameter [6:0] AOUT_SLOT = 7'h03,
	parameter [7:0] AIN_TYPE_ID = 8'hA1, // arbitrary value
	parameter [7:0] TEMP_TYPE_ID = 8'hA2, // arbitrary value
	parameter [7:0] AOUT_TYPE_ID = 8'hA3 // arbitrary value
) (
	clk,
	rst_n,
	reqValid,
	reqFunc,
	reqAddr,
	reqCount,
	wrValid,
	wrData,
	ainPresent,
	ainLinkOk,
	ainValid,
	ainData,
	tempPresent,
	tempLinkOk,
	tempValid,
	tempData,
	aoutPresent,
	busy_r,
	rdValid_r,
	rdData_r,
	wrTake_r,
	done_r,
	excCode_r,
	analogOutFirst_r,
	analogOutSecond_r,
	analogOutThird_r,
	analogOutFourth_r,
	aoutFresh_r
);
	input wire clk;
	input wire rst_n;
	input wire reqValid;
	input wire [7:0] reqFunc;
	input wire [15:0] reqAddr;
	input wire [6:0] reqCount;
	input wire wrValid;
	input wire [15:0] wrData;
	input wire ainPresent;
	input wire ainLinkOk;
	input wire ainValid;
	input wire [63:0] ainData;
	input wire tempPresent;
	input wire tempLinkOk;
	input wire tempValid;
	input wire [63:0] tempData;
	input wire aoutPresent;
	output reg busy_r;
	output reg rdValid_r;
	output reg [15:0] rdData_r;
	output reg wrTake_r;
	output reg done_r;
	output reg [7:0] excCode_r;
	output reg [15:0] analogOutFirst_r;
	output reg [15:0] analogOutSecond_r;
	output reg [15:0] analogOutThird_r;
	output reg [15:0] analogOutFourth_r;
	output reg aoutFresh_r;

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_READ = 2'b01;
	localparam [1:0] ST_WRITE = 2'b10;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [15:0] addr_r;
	reg [6:0] left_r;
	reg isInput_r;
	reg [63:0] ain_r;
	reg [63:0] temp_r;
	wire [6:0] slotNum;
	wire [3:0] wordIdx;

	// first word of a slot: type low, freshness at bit 8
	function [15:0] headWord;
		input present;
		input stale;
		input [7:0] typeId;
		begin
			headWord = 16'h0000;
			headWord[`AIOM_FRESH_BIT] = stale;
			headWord[`AIOM_TYPE_LSB +: `AIOM_TYPE_W] = present ? typeId : 8'h00;
		end
	endfunction

	// channel pick; x1 and x6..x9 fall to zero
	function [15:0] chanWord;
		input [3:0] idx;
		input [63:0] chans;
		begin
			chanWord = 16'h0000;
			if (idx >= `AIOM_IDX_CH1 && idx <= `AIOM_IDX_CH4) begin
				chanWord = chans[(idx - `AIOM_IDX_CH1) * 16 +: 16];
			end
		end
	endfunction

	aiom_slot_decode u_aiom_slot_decode (
		.addr(addr_r),
		.slotNum(slotNum),
		.wordIdx(wordIdx)
	);

	wire [63:0] aoutAll = {analogOutFourth_r, analogOutThird_r, analogOutSecond_r, analogOutFirst_r};
	wire reqOk = (reqFunc == `AIOM_FC_READ_HOLD) || (reqFunc == `AIOM_FC_READ_INPUT)
		|| (reqFunc == `AIOM_FC_WRITE_MULTI);
	wire cntOk = (reqCount != 7'h00) && (reqCount <= `AIOM_MAX_COUNT);
	// last word of the request must stay inside the map
	wire addrOk = ({1'b0, reqAddr} + {10'h000, reqCount}) <= `AIOM_ADDR_LIMIT;

	reg [15:0] readWord;
	always @* begin
		readWord = 16'h0000;
		if (isInput_r) begin
			if (slotNum == AIN_SLOT) begin
				readWord = (wordIdx == `AIOM_IDX_TYPE) ? headWord(ainPresent, ~ainLinkOk, AIN_TYPE_ID)
					: chanWord(wordIdx, ain_r);
			end else if (slotNum == TEMP_SLOT) begin
				readWord = (wordIdx == `AIOM_IDX_TYPE) ? headWord(tempPresent, ~tempLinkOk, TEMP_TYPE_ID)
					: chanWord(wordIdx, temp_r);
			end
		end else if (slotNum == AOUT_SLOT) begin
			readWord = (wordIdx == `AIOM_IDX_TYPE) ? headWord(aoutPresent, aoutFresh_r, AOUT_TYPE_ID)
				: chanWord(wordIdx, aoutAll);
		end
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (reqValid && reqOk && cntOk && addrOk) begin
					state_nxt = (reqFunc == `AIOM_FC_WRITE_MULTI) ? ST_WRITE : ST_READ;
				end
			end
			ST_READ: begin
				if (left_r == 7'h01) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (wrValid && left_r == 7'h01) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	wire wrHit = (state_r == ST_WRITE) && wrValid && (slotNum == AOUT_SLOT);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			addr_r <= 16'h0000;
			left_r <= 7'h00;
			isInput_r <= 1'b0;
			busy_r <= 1'b0;
			rdValid_r <= 1'b0;
			rdData_r <= 16'h0000;
			wrTake_r <= 1'b0;
			done_r <= 1'b0;
			excCode_r <= `AIOM_EXC_NONE;
			ain_r <= 64'h0;
			temp_r <= 64'h0;
			analogOutFirst_r <= `AIOM_CH_RESET;
			analogOutSecond_r <= `AIOM_CH_RESET;
			analogOutThird_r <= `AIOM_CH_RESET;
			analogOutFourth_r <= `AIOM_CH_RESET;
			aoutFresh_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			rdValid_r <= 1'b0;
			wrTake_r <= 1'b0;
			done_r <= 1'b0;
			// stale inputs keep their last values
			if (ainValid && ainLinkOk) begin
				ain_r <= ainData;
			end
			if (tempValid && tempLinkOk) begin
				temp_r <= tempData;
			end
			case (state_r)
				ST_IDLE: begin
					if (reqValid) begin
						addr_r <= reqAddr;
						left_r <= reqCount;
						isInput_r <= (reqFunc == `AIOM_FC_READ_INPUT);
						busy_r <= reqOk && cntOk && addrOk;
						if (!reqOk) begin
							excCode_r <= `AIOM_EXC_FUNC;
							done_r <= 1'b1;
						end else if (!cntOk) begin
							excCode_r <= `AIOM_EXC_VALUE;
							done_r <= 1'b1;
						end else if (!addrOk) begin
							excCode_r <= `AIOM_EXC_ADDR;
							done_r <= 1'b1;
						end else begin
							excCode_r <= `AIOM_EXC_NONE;
						end
					end
				end
				ST_READ: begin
					rdValid_r <= 1'b1;
					rdData_r <= readWord;
					addr_r <= addr_r + 16'h0001;
					left_r <= left_r - 7'h01;
					if (left_r == 7'h01) begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
					end
				end
				ST_WRITE: begin
					if (wrValid) begin
						wrTake_r <= 1'b1;
						addr_r <= addr_r + 16'h0001;
						left_r <= left_r - 7'h01;
						if (left_r == 7'h01) begin
							busy_r <= 1'b0;
							done_r <= 1'b1;
						end
					end
				end
				default: begin
					busy_r <= 1'b0;
				end
			endcase
			// any write into the slot, reserved words included, marks data current
			if (wrHit) begin
				aoutFresh_r <= 1'b0;
				case (wordIdx)
					4'h2: analogOutFirst_r <= wrData;
					4'h3: analogOutSecond_r <= wrData;
					4'h4: analogOutThird_r <= wrData;
					4'h5: analogOutFourth_r <= wrData;
					default: analogOutFirst_r <= analogOutFirst_r;
				endcase
			end
		end
	end
endmodule

// ===== sim/aiom_map_monitor.sv
/*
 checker on the aiom_map ports, bound to every aiom_map.
 assumes one clock and rst_n as its reset.
*/
`timescale 1ns/1ps
module aiom_map_monitor (
	input wire clk,
	input wire rst_n,
	input wire reqValid,
	input wire busy_r,
	input wire rdValid_r,
	input wire wrTake_r,
	input wire done_r,
	input wire aoutFresh_r,
	input wire [7:0] reqFunc,
	input wire [7:0] excCode_r,
	input wire [6:0] reqCount,
	input wire [15:0] reqAddr,
	input wire [15:0] analogOutFirst_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// low addresses only, so no address fault can mask the others
	wire tk = reqValid && !busy_r && reqAddr < 16'h0100;
	property p_fc;
		tk && reqFunc != 8'h03 && reqFunc != 8'h04 && reqFunc != 8'h10 |=> done_r && excCode_r == 8'h01;
	endproperty
	a_fc: assert property (p_fc) else $error("bad code not refused");
	property p_cn;
		tk && reqFunc == 8'h04 && (reqCount == 7'h00 || reqCount > 7'h7B) |=> done_r && excCode_r == 8'h03;
	endproperty
	a_cn: assert property (p_cn) else $error("bad count not refused");
	property p_rd;
		tk && reqFunc == 8'h04 && reqCount == 7'h0A |=> busy_r && !rdValid_r ##1 rdValid_r [*8];
	endproperty
	a_rd: assert property (p_rd) else $error("read words late or gapped");
	property p_dn;
		$fell(busy_r) |-> done_r;
	endproperty
	a_dn: assert property (p_dn) else $error("busy ended without done");
	property p_ex;
		done_r && excCode_r != 8'h00 |-> !rdValid_r && !busy_r;
	endproperty
	a_ex: assert property (p_ex) else $error("refused request gave data");
	property p_f1;
		$fell(aoutFresh_r) |-> wrTake_r;
	endproperty
	a_f1: assert property (p_f1) else $error("flag cleared without write");
	property p_f2;
		!aoutFresh_r |=> !aoutFresh_r;
	endproperty
	a_f2: assert property (p_f2) else $error("flag set again");
	property p_ch;
		$changed(analogOutFirst_r) |-> wrTake_r;
	endproperty
	a_ch: assert property (p_ch) else $error("output moved without write");
	cover property (done_r && excCode_r == 8'h02);
	cover property ($fell(aoutFresh_r));
	cover property (rdValid_r ##1 rdValid_r);
endmodule
bind aiom_map aiom_map_monitor u_aiom_map_monitor (.*);

// ===== sim/aiom_master_model.sv
/*
 master-side model: issues one request per txn call, collects read words.
 assumes the bench calls txn from one process only.
*/
`timescale 1ns/1ps
module aiom_master_model (
	input wire clk,
	input wire done_r,
	input wire rdValid_r,
	input wire [7:0] excCode_r,
	input wire [15:0] rdData_r,
	output reg reqValid = 0,
	output reg wrValid = 0,
	output reg [7:0] reqFunc = 0,
	output reg [15:0] reqAddr = 0,
	output reg [15:0] wrData = 0,
	output reg [6:0] reqCount = 0
);
	reg [15:0] rd [0:127];
	reg [7:0] nr = 0;
	reg [7:0] ex = 0;
	reg dn = 0;
	integer hung = 0;
	always @(posedge clk) begin
		if (rdValid_r === 1'b1) begin
			rd[nr] <= rdData_r;
			nr <= nr + 8'h01;
		end
		if (done_r === 1'b1) begin
			dn <= 1'b1;
			ex <= excCode_r;
		end
	end
	task txn(input [7:0] f, input [15:0] num, input [6:0] n, input [63:0] w);
		integer i;
		begin
			@(posedge clk);
			reqValid <= 1'b1;
			reqFunc <= f;
			reqAddr <= num - 16'h0001;
			reqCount <= n;
			nr <= 8'h00;
			dn <= 1'b0;
			@(posedge clk);
			reqValid <= 1'b0;
			// spaced words: one strobe, then a quiet edge
			for (i = 0; f == 8'h10 && i < n && i < 4; i = i + 1) begin
				wrValid <= 1'b1;
				wrData <= w[16 * i +: 16];
				@(posedge clk);
				wrValid <= 1'b0;
				@(posedge clk);
			end
			for (i = 0; dn !== 1'b1 && i < 300; i = i + 1)
				@(posedge clk);
			if (dn !== 1'b1)
				hung = hung + 1;
		end
	endtask
endmodule

// ===== sim/tb_aiom_map.sv
/*
 self-checking bench for aiom_map, requests through the master model.
 assumes the default slot numbers and type codes.
*/
`timescale 1ns/1ps
module tb_aiom_map;
	reg clk = 0, rst_n = 0, ainPresent = 0, ainLinkOk = 0, ainValid = 0, aoutPresent = 0;
	reg tempPresent = 0, tempLinkOk = 0, tempValid = 0, p, l;
	reg [63:0] ainData = 0, tempData = 0, w;
	reg [63:0] hold [1:2];
	wire reqValid, wrValid, busy_r, rdValid_r, wrTake_r, done_r, aoutFresh_r;
	wire [7:0] reqFunc, excCode_r;
	wire [15:0] reqAddr, wrData, rdData_r, analogOutFirst_r, analogOutSecond_r;
	wire [15:0] analogOutThird_r, analogOutFourth_r;
	wire [6:0] reqCount;
	integer n_errors = 0, total_checks = 0, seed = 32'h01e6, j, i, s;
	aiom_map u_aiom_map (.*);
	aiom_master_model u_aiom_master_model (.*);
	function [15:0] expWord(input integer k, input pr, input lk, input [7:0] t, input [63:0] c);
		expWord = k == 0 ? {7'h00, !lk, pr ? t : 8'h00} : (k > 1 && k < 6) ? c[16 * (k - 2) +: 16] : 16'h0000;
	endfunction
	task chk(input [15:0] got, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task err(input [7:0] f, input [15:0] num, input [6:0] n, input [7:0] e);
		begin
			u_aiom_master_model.txn(f, num, n, 64'h0);
			chk(u_aiom_master_model.ex, e);
			chk(u_aiom_master_model.nr, 16'h0000);
		end
	endtask
	task tally_and_finish;
		begin
			n_errors = n_errors + u_aiom_master_model.hung;
			$display("checks=%0d errors=%0d", total_checks, n_errors);
			if (n_errors == 0 && total_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial forever #4 clk = ~clk;
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		aoutPresent <= 1'b1;
		chk(aoutFresh_r, 16'h0001);
		// first pass fresh and present so the held samples are known
		for (j = 0; j < 4; j = j + 1) begin
			p = j == 0 ? 1'b1 : $random(seed);
			l = j == 0 ? 1'b1 : $random(seed);
			w = {$random(seed), $random(seed)};
			@(posedge clk);
			{ainPresent, ainLinkOk, tempPresent, tempLinkOk} <= {p, l, p, l};
			ainData <= w;
			tempData <= ~w;
			@(posedge clk);
			{ainValid, tempValid} <= 2'b11;
			@(posedge clk);
			{ainValid, tempValid} <= 2'b00;
			if (l) begin
				hold[1] = w;
				hold[2] = ~w;
			end
			for (s = 1; s < 3; s = s + 1) begin
				u_aiom_master_model.txn(8'h04, s * 10, 7'h0A, 64'h0);
				for (i = 0; i < 10; i = i + 1)
					chk(u_aiom_master_model.rd[i], expWord(i, p, l, s == 1 ? 8'hA1 : 8'hA2, hold[s]));
				chk(u_aiom_master_model.nr, 16'h000A);
			end
		end
		u_aiom_master_model.txn(8'h03, 16'd30, 7'h0A, 64'h0);
		for (i = 0; i < 10; i = i + 1)
			chk(u_aiom_master_model.rd[i], expWord(i, 1'b1, 1'b0, 8'hA3, 64'h0));
		u_aiom_master_model.txn(8'h10, 16'd31, 7'h01, 64'hFFFF);
		chk(aoutFresh_r, 16'h0000);
		chk(analogOutFirst_r, 16'h0000);
		w = {$random(seed), $random(seed)};
		u_aiom_master_model.txn(8'h10, 16'd32, 7'h04, w);
		chk(analogOutFirst_r, w[15:0]);
		chk(analogOutSecond_r, w[31:16]);
		chk(analogOutThird_r, w[47:32]);
		chk(analogOutFourth_r, w[63:48]);
		u_aiom_master_model.txn(8'h03, 16'd30, 7'h0A, 64'h0);
		for (i = 0; i < 10; i = i + 1)
			chk(u_aiom_master_model.rd[i], expWord(i, 1'b1, 1'b1, 8'hA3, w));
		chk(u_aiom_master_model.ex, 16'h0000);
		err(8'h06, 16'h0001, 7'h01, 8'h01);
		err(8'h01, 16'h0001, 7'h01, 8'h01);
		err(8'h04, 16'h0001, 7'h00, 8'h03);
		err(8'h10, 16'h0001, 7'h7C, 8'h03);
		err(8'h04, 16'd1000, 7'h02, 8'h02);
		u_aiom_master_model.txn(8'h04, 16'h0001, 7'h7B, 64'h0);
		chk(u_aiom_master_model.nr, 16'h007B);
		tally_and_finish;
	end
endmodule
